/* File: design/periph_irq_status.sv */
// peripheral interrupt enables, sticky flags and power/reset status registers
// Operation
// - group enable low blocks every peripheral interrupt
// - per-source enable bits 6,5,3,1,0
// - unimplemented bits read zero, ignore writes
// - reduced variant drops adc, capcmp, timer2 bits
// - flags set regardless of any enable
// - adc flag set on conversion done
// - capcmp flag on capture/compare, never pwm
// - comparator flag on output change, sticky
// - timer2 flag on period match, sticky
// - timer1 flag on overflow, software clear only
// - power-on reset drives por bit low
// - brown-out reset drives bor bit low
// - bor bit reads zero while brown-out disabled
// - register holds brown-out reset software enable
// - group enable is control bit 6
// - global enable low blocks all interrupts
`timescale 1ns/1ps
module periph_irq_status #(
   parameter bit FULL_VARIANT = 1'b1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [irq_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [irq_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // peripheral events
   input wire logic adc_done_evt,
   input wire logic capcmp_capture_evt,
   input wire logic capcmp_compare_evt,
   input wire irq_pkg::capcmp_mode_t capcmp_mode,
   input wire logic comparator_out,
   input wire logic timer_two_match_evt,
   input wire logic timer_one_ovf_evt,
   // reset sources
   input wire logic power_on_reset_evt,
   input wire logic brownout_reset_evt,
   // gates from the global interrupt control register
   input wire logic global_irq_en,
   input wire logic periph_group_irq_en,
   // to the core and the reset circuit
   output logic periph_irq_req,
   output logic brownout_reset_en
);
   localparam logic [7:0] IMPL = FULL_VARIANT ? irq_pkg::IMPL_FULL : irq_pkg::IMPL_REDUCED;

   logic wr_en;
   logic [irq_pkg::ADDR_W-1:0] wr_addr;
   logic [irq_pkg::ADDR_W-1:0] rd_addr;
   logic [31:0] wr_data;
   logic [31:0] rd_data;
   logic [3:0] wr_strb;
   // per-register write strobes
   logic en_wr;
   logic flag_wr;
   logic power_wr;
   logic bor_ctrl_wr;
   // register state
   logic [7:0] periph_irq_enable_q;
   logic [7:0] periph_irq_enable_d;
   logic [7:0] periph_irq_flags_q;
   logic [7:0] power_control_status_q;
   logic bor_en_q;
   logic bor_en_d;
   // event conditioning
   logic [7:0] flag_evt;
   logic [7:0] power_evt;
   logic cmp_prev_q;
   logic cmp_prev_d;
   logic cmp_seen_q;
   logic cmp_seen_d;
   logic capcmp_evt;
   logic cmp_change;
   // request to the core
   logic irq_q;
   logic irq_d;

   // bus slave
   axil_regs_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // write strobe of one register; only the low byte lane carries register bits
   function automatic logic write_hit(input logic en, input logic [3:0] strb,
      input logic [irq_pkg::ADDR_W-1:0] a, input logic [irq_pkg::ADDR_W-1:0] off);
      return en && strb[0] && (a == off);
   endfunction

   // write decode
   assign en_wr = write_hit(wr_en, wr_strb, wr_addr, irq_pkg::OFF_ENABLE);
   assign flag_wr = write_hit(wr_en, wr_strb, wr_addr, irq_pkg::OFF_FLAGS);
   assign power_wr = write_hit(wr_en, wr_strb, wr_addr, irq_pkg::OFF_POWER);
   assign bor_ctrl_wr = write_hit(wr_en, wr_strb, wr_addr, irq_pkg::OFF_BOR_CTRL);

   // event conditioning; capcmp only reports in capture or compare mode
   always_comb begin
      capcmp_evt = ((capcmp_mode == irq_pkg::MODE_CAPTURE) && capcmp_capture_evt)
         || ((capcmp_mode == irq_pkg::MODE_COMPARE) && capcmp_compare_evt);
      // no edge before the first sample, so reset does not fake a change
      cmp_change = cmp_seen_q && (comparator_out != cmp_prev_q);
      cmp_prev_d = comparator_out;
      cmp_seen_d = 1'b1;
      flag_evt = 8'h00;
      flag_evt[irq_pkg::BIT_ADC] = adc_done_evt;
      flag_evt[irq_pkg::BIT_CAPCMP] = capcmp_evt;
      flag_evt[irq_pkg::BIT_CMP] = cmp_change;
      flag_evt[irq_pkg::BIT_T2] = timer_two_match_evt;
      flag_evt[irq_pkg::BIT_T1] = timer_one_ovf_evt;
      power_evt = 8'h00;
      power_evt[irq_pkg::BIT_POR] = power_on_reset_evt;
      power_evt[irq_pkg::BIT_BOR] = brownout_reset_evt;
   end

   // sticky flags, set independent of any enable; set beats a clearing write
   event_status_reg #(
      .IMPL(IMPL),
      .RST(irq_pkg::FLAGS_RST),
      .HW_VAL(1'b1)
   ) u_flags (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(flag_wr),
      .wr_data(wr_data[7:0]),
      .evt(flag_evt),
      .value_q(periph_irq_flags_q)
   );

   // reset status: reset events force bits low, software writes them high
   event_status_reg #(
      .IMPL(irq_pkg::IMPL_POWER),
      .RST(irq_pkg::POWER_RST),
      .HW_VAL(1'b0)
   ) u_power (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(power_wr),
      .wr_data(wr_data[7:0]),
      .evt(power_evt),
      .value_q(power_control_status_q)
   );

   // enables and brown-out control
   always_comb begin
      periph_irq_enable_d = periph_irq_enable_q;
      if (en_wr) begin
         periph_irq_enable_d = wr_data[7:0] & IMPL;
      end
      bor_en_d = bor_ctrl_wr ? wr_data[irq_pkg::BIT_BOR_EN] : bor_en_q;
   end

   // request: both gates must be open; registered so the core sees a clean level
   always_comb begin
      irq_d = global_irq_en && periph_group_irq_en
         && (|(periph_irq_flags_q & periph_irq_enable_q));
   end

   // read mux; bor status is masked rather than cleared, so it returns on re-enable
   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (rd_addr)
         irq_pkg::OFF_ENABLE: begin
            rd_data[7:0] = periph_irq_enable_q;
         end
         irq_pkg::OFF_FLAGS: begin
            rd_data[7:0] = periph_irq_flags_q;
         end
         irq_pkg::OFF_POWER: begin
            rd_data[7:0] = power_control_status_q;
            rd_data[irq_pkg::BIT_BOR] = power_control_status_q[irq_pkg::BIT_BOR] && bor_en_q;
         end
         irq_pkg::OFF_BOR_CTRL: begin
            rd_data[irq_pkg::BIT_BOR_EN] = bor_en_q;
         end
         default: begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   // state registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periph_irq_enable_q <= irq_pkg::ENABLE_RST;
         bor_en_q <= irq_pkg::BOR_EN_RST;
         cmp_prev_q <= 1'b0;
         cmp_seen_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         periph_irq_enable_q <= periph_irq_enable_d;
         bor_en_q <= bor_en_d;
         cmp_prev_q <= cmp_prev_d;
         cmp_seen_q <= cmp_seen_d;
         irq_q <= irq_d;
      end
   end

   assign periph_irq_req = irq_q;
   assign brownout_reset_en = bor_en_q;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // interrupt gating
   group_gate_a: assert property (!periph_group_irq_en |=> !periph_irq_req)
      else $error("peripheral request raised with group enable low");
   global_gate_a: assert property (!global_irq_en |=> !periph_irq_req)
      else $error("peripheral request raised with global enable low");
   irq_combine_a: assert property (
      (global_irq_en && periph_group_irq_en && |(periph_irq_flags_q & periph_irq_enable_q))
      |=> periph_irq_req)
      else $error("enabled pending flag did not raise the request");
   req_needs_flag_a: assert property (
      !(|(periph_irq_flags_q & periph_irq_enable_q)) |=> !periph_irq_req)
      else $error("request raised with no enabled pending flag");

   // register contents
   unimpl_zero_a: assert property (
      ((periph_irq_flags_q | periph_irq_enable_q) & ~IMPL) == 8'h00
      && (power_control_status_q & ~irq_pkg::IMPL_POWER) == 8'h00)
      else $error("unimplemented bit holds a one");
   enable_write_a: assert property (en_wr |=> periph_irq_enable_q == ($past(wr_data[7:0]) & IMPL))
      else $error("enable register did not take the written value");
   bor_mask_a: assert property (
      (!bor_en_q && rd_addr == irq_pkg::OFF_POWER) |-> !rd_data[irq_pkg::BIT_BOR])
      else $error("brown-out status visible while disabled");

   // event capture
   adc_set_a: assert property (
      (adc_done_evt && IMPL[irq_pkg::BIT_ADC]) |=> periph_irq_flags_q[irq_pkg::BIT_ADC])
      else $error("conversion done did not set the adc flag");
   capcmp_set_a: assert property (
      (capcmp_evt && IMPL[irq_pkg::BIT_CAPCMP]) |=> periph_irq_flags_q[irq_pkg::BIT_CAPCMP])
      else $error("capture or compare event did not set its flag");
   pwm_silent_a: assert property (
      (capcmp_mode == irq_pkg::MODE_PWM && !flag_wr && !periph_irq_flags_q[irq_pkg::BIT_CAPCMP])
      |=> !periph_irq_flags_q[irq_pkg::BIT_CAPCMP])
      else $error("capcmp flag set in pwm mode");
   cmp_set_a: assert property (cmp_change |=> periph_irq_flags_q[irq_pkg::BIT_CMP])
      else $error("comparator change did not set its flag");
   cmp_sticky_a: assert property (
      (periph_irq_flags_q[irq_pkg::BIT_CMP] && !flag_wr) |=> periph_irq_flags_q[irq_pkg::BIT_CMP])
      else $error("comparator flag dropped without a write");
   t2_set_a: assert property (
      (timer_two_match_evt && IMPL[irq_pkg::BIT_T2]) |=> periph_irq_flags_q[irq_pkg::BIT_T2])
      else $error("timer2 match did not set its flag");
   t1_set_a: assert property (timer_one_ovf_evt |=> periph_irq_flags_q[irq_pkg::BIT_T1])
      else $error("timer1 overflow did not set its flag");
   t1_sticky_a: assert property (
      (periph_irq_flags_q[irq_pkg::BIT_T1] && !flag_wr) |=> periph_irq_flags_q[irq_pkg::BIT_T1])
      else $error("timer1 flag cleared by hardware");

   // reset status
   por_clear_a: assert property (power_on_reset_evt |=> !power_control_status_q[irq_pkg::BIT_POR])
      else $error("power-on reset did not clear its status bit");
   bor_clear_a: assert property (brownout_reset_evt |=> !power_control_status_q[irq_pkg::BIT_BOR])
      else $error("brown-out reset did not clear its status bit");

   // main scenarios
   irq_raised_c: cover property (!periph_irq_req ##1 periph_irq_req);
   irq_dropped_c: cover property (periph_irq_req ##1 !periph_irq_req);
   flag_clear_c: cover property (flag_wr && periph_irq_flags_q != 8'h00);
   bor_seen_c: cover property (brownout_reset_evt && bor_en_q);
   clash_c: cover property (flag_wr && timer_one_ovf_evt && !wr_data[irq_pkg::BIT_T1]);
endmodule // periph_irq_status

/* File: include/irq_pkg.sv */
// shared constants for the peripheral interrupt and reset status block
package irq_pkg;
   // register map, byte addresses on the 32-bit register bus
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_ENABLE = 8'h00;
   localparam logic [7:0] OFF_FLAGS = 8'h04;
   localparam logic [7:0] OFF_POWER = 8'h08;
   localparam logic [7:0] OFF_BOR_CTRL = 8'h0C;
   // bit positions in the enable and flag registers
   localparam int BIT_ADC = 6;
   localparam int BIT_CAPCMP = 5;
   localparam int BIT_CMP = 3;
   localparam int BIT_T2 = 1;
   localparam int BIT_T1 = 0;
   // bit positions in the power control register and brown-out control
   localparam int BIT_POR = 1;
   localparam int BIT_BOR = 0;
   localparam int BIT_BOR_EN = 0;
   // implemented bit masks for the two build variants and the power control register
   localparam logic [7:0] IMPL_FULL = 8'h6B;
   localparam logic [7:0] IMPL_REDUCED = 8'h09;
   localparam logic [7:0] IMPL_POWER = 8'h03;
   // reset values
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] POWER_RST = 8'h00;
   localparam logic BOR_EN_RST = 1'b1;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // operating mode of the capture/compare unit
   typedef enum logic [1:0] {MODE_OFF, MODE_CAPTURE, MODE_COMPARE, MODE_PWM} capcmp_mode_t;

   // true for an address that hits one of the four registers
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == OFF_ENABLE) || (a == OFF_FLAGS) || (a == OFF_POWER) || (a == OFF_BOR_CTRL);
   endfunction
endpackage

/* File: design/axil_regs_slave.sv */
// axi4-lite slave front end: single write and single read in flight
`timescale 1ns/1ps
module axil_regs_slave (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address and data channels
   input wire logic [irq_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read channels
   input wire logic [irq_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // register side
   output logic wr_en,
   output logic [irq_pkg::ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   output logic [irq_pkg::ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_data
);
   logic aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic [irq_pkg::ADDR_W-1:0] aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic aw_take, w_take, ar_take;

   // a channel is taken only while its holding slot is free
   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready = !w_held_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign aw_take = s_axi_awvalid && !aw_held_q;
   assign w_take = s_axi_wvalid && !w_held_q;
   assign ar_take = s_axi_arvalid && !rvalid_q;
   assign rd_addr = s_axi_araddr;

   // write path: address and data in either order, commit when both present
   always_comb begin
      aw_held_d = aw_held_q || aw_take;
      w_held_d = w_held_q || w_take;
      aw_addr_d = aw_take ? s_axi_awaddr : aw_addr_q;
      w_data_d = w_take ? s_axi_wdata : w_data_q;
      w_strb_d = w_take ? s_axi_wstrb : w_strb_q;
      wr_addr = aw_take ? s_axi_awaddr : aw_addr_q;
      wr_data = w_take ? s_axi_wdata : w_data_q;
      wr_strb = w_take ? s_axi_wstrb : w_strb_q;
      // commit waits for the previous response so only one is ever pending
      wr_en = aw_held_d && w_held_d && !bvalid_q;
      bvalid_d = bvalid_q && !s_axi_bready;
      bresp_d = bresp_q;
      if (wr_en) begin
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = irq_pkg::is_mapped(wr_addr) ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR;
      end
   end

   // read path: data captured on the address handshake
   always_comb begin
      rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
      rdata_d = ar_take ? rd_data : rdata_q;
      rresp_d = rresp_q;
      if (ar_take) begin
         rresp_d = irq_pkg::is_mapped(s_axi_araddr) ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR;
      end
   end

   // state registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= irq_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= irq_pkg::RESP_OKAY;
         rdata_q <= '0;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         aw_addr_q <= aw_addr_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end
endmodule // axil_regs_slave

/* File: design/event_status_reg.sv */
// status register whose bits software writes and hardware events force
`timescale 1ns/1ps
module event_status_reg #(
   parameter logic [7:0] IMPL = 8'hFF,
   parameter logic [7:0] RST = 8'h00,
   parameter logic HW_VAL = 1'b1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // software write
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   // hardware events, one bit per position
   input wire logic [7:0] evt,
   // state
   output logic [7:0] value_q
);
   logic [7:0] value_d;

   // event is applied after the write so the event wins a same-cycle clash
   always_comb begin
      value_d = wr_en ? wr_data : value_q;
      if (HW_VAL) begin
         value_d = value_d | evt;
      end else begin
         value_d = value_d & ~evt;
      end
      // unimplemented bits never store anything
      value_d = value_d & IMPL;
   end

   // register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         value_q <= RST & IMPL;
      end else begin
         value_q <= value_d;
      end
   end
endmodule // event_status_reg

/* File: testbench/periph_event_model.sv */
// behavioural model of the peripheral event sources and the reset circuit
`timescale 1ns/1ps
module periph_event_model (
   // clock
   input wire logic aclk,
   // event strobes to the block
   output logic adc_done_evt,
   output logic capcmp_capture_evt,
   output logic capcmp_compare_evt,
   output logic timer_two_match_evt,
   output logic timer_one_ovf_evt,
   output logic power_on_reset_evt,
   output logic brownout_reset_evt,
   // levels to the block
   output irq_pkg::capcmp_mode_t capcmp_mode,
   output logic comparator_out
);
   logic [6:0] pulse_q;

   // one bit per source, index order is the fire selector
   assign {brownout_reset_evt, power_on_reset_evt, adc_done_evt, capcmp_capture_evt, capcmp_compare_evt,
      timer_two_match_evt, timer_one_ovf_evt} = pulse_q;

   // quiet sources at time zero so no flag starts unknown
   initial begin
      pulse_q = 7'h00;
      capcmp_mode = irq_pkg::MODE_OFF;
      comparator_out = 1'b0;
   end

   // one-cycle strobe; the extra edge keeps two strobes from merging
   task automatic fire(input int sel);
      pulse_q <= 7'h01 << sel;
      @(posedge aclk);
      pulse_q <= 7'h00;
      @(posedge aclk);
   endtask

   // comparator output flips once
   task automatic toggle_cmp();
      comparator_out <= ~comparator_out;
      @(posedge aclk);
   endtask

   // capture/compare unit changes mode
   task automatic set_mode(input irq_pkg::capcmp_mode_t m);
      capcmp_mode <= m;
      @(posedge aclk);
   endtask
endmodule // periph_event_model

/* File: testbench/periph_irq_and_reset_status_test.sv */
// self-checking bench for the peripheral interrupt and reset status block
`timescale 1ns/1ps
module periph_irq_and_reset_status_test;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdata_red, rd_q;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic adc_done_evt, capcmp_capture_evt, capcmp_compare_evt, comparator_out;
   logic timer_two_match_evt, timer_one_ovf_evt, power_on_reset_evt, brownout_reset_evt;
   irq_pkg::capcmp_mode_t capcmp_mode;
   logic global_irq_en, periph_group_irq_en, periph_irq_req, brownout_reset_en;
   int failures, n_compared;
   logic [7:0] flag_tab [5] = '{8'h01, 8'h02, 8'h20, 8'h20, 8'h40};
   int bit_tab [5] = '{0, 1, 3, 5, 6};

   // full build under test
   periph_irq_status #(.FULL_VARIANT(1'b1)) dut (.*);
   // reduced build shares the bus and events; only its read data is watched
   periph_irq_status #(.FULL_VARIANT(1'b0)) dut_red (.*, .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(),
      .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(rdata_red), .s_axi_rresp(), .s_axi_rvalid(),
      .periph_irq_req(), .brownout_reset_en());
   // event sources and reset circuit
   periph_event_model src (.*);

   // 50 MHz clock
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // count a comparison, report a mismatch at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // request line to the core
   task automatic chk_req(input logic exp);
      chk({31'h0000_0000, periph_irq_req}, {31'h0000_0000, exp}, "interrupt request");
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask

   // bus write: address and data offered together, each dropped once taken; bready up until the answer
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = irq_pkg::RESP_OKAY,
      input logic [3:0] s = 4'hF);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(n, 32'h0000_0002, "write latency");
      chk({30'h0000_0000, s_axi_bresp}, {30'h0000_0000, er}, "write response");
      // one idle edge so the next call never reassigns bready in this step
      @(posedge aclk);
   endtask

   // bus read; the reduced build's data is kept in rd_q
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = irq_pkg::RESP_OKAY);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rd_q = rdata_red;
      chk(n, 32'h0000_0002, "read latency");
      chk(s_axi_rdata, exp, "read data");
      chk({30'h0000_0000, s_axi_rresp}, {30'h0000_0000, er}, "read response");
      @(posedge aclk);
   endtask

   task automatic give_verdict();
      $display("compared %0d values, %0d failures", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      $display("unexpected at %0t: run did not finish", $time);
      give_verdict();
   end

   initial begin
      failures = 0;
      n_compared = 0;
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_rready = 1'b0;
      global_irq_en = 1'b0;
      periph_group_irq_en = 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // reset values, unmapped hole, writable masks of both builds
      rd(irq_pkg::OFF_ENABLE, 32'h0000_0000);
      rd(irq_pkg::OFF_FLAGS, 32'h0000_0000);
      rd(irq_pkg::OFF_POWER, 32'h0000_0000);
      rd(irq_pkg::OFF_BOR_CTRL, 32'h0000_0001);
      chk({31'h0000_0000, brownout_reset_en}, 32'h0000_0001, "brown-out enable");
      rd(8'h10, 32'h0000_0000, irq_pkg::RESP_SLVERR);
      wr(8'h10, 8'hFF, irq_pkg::RESP_SLVERR);
      wr(irq_pkg::OFF_ENABLE, 8'hFF);
      rd(irq_pkg::OFF_ENABLE, 32'h0000_006B);
      chk(rd_q, 32'h0000_0009, "reduced enables");
      wr(irq_pkg::OFF_ENABLE, 8'h00);
      rd(irq_pkg::OFF_ENABLE, 32'h0000_0000);
      // a write without byte lane 0 is answered but changes nothing
      wr(irq_pkg::OFF_ENABLE, 8'hFF, irq_pkg::RESP_OKAY, 4'hE);
      rd(irq_pkg::OFF_ENABLE, 32'h0000_0000);
      // each peripheral event strobe sets its flag with every enable and gate closed
      src.set_mode(irq_pkg::MODE_COMPARE);
      for (int i = 0; i < 5; i++) begin
         if (i == 3) src.set_mode(irq_pkg::MODE_CAPTURE);
         src.fire(i);
         rd(irq_pkg::OFF_FLAGS, {24'h00_0000, flag_tab[i]});
         chk(rd_q, {24'h00_0000, flag_tab[i] & 8'h09}, "reduced flags");
         chk_req(1'b0);
         wr(irq_pkg::OFF_FLAGS, 8'h00);
      end
      // capture and compare strobes are ignored when the unit is off or in pwm
      for (int m = 0; m < 2; m++) begin
         src.set_mode(m == 0 ? irq_pkg::MODE_OFF : irq_pkg::MODE_PWM);
         src.fire(2);
         src.fire(3);
         rd(irq_pkg::OFF_FLAGS, 32'h0000_0000);
      end
      // comparator change is sticky until software clears it
      src.toggle_cmp();
      tick(2);
      rd(irq_pkg::OFF_FLAGS, 32'h0000_0008);
      tick(20);
      rd(irq_pkg::OFF_FLAGS, 32'h0000_0008);
      wr(irq_pkg::OFF_FLAGS, 8'h00);
      rd(irq_pkg::OFF_FLAGS, 32'h0000_0000);
      // both gates must be open for a pending timer one overflow to reach the core
      src.fire(0);
      wr(irq_pkg::OFF_FLAGS, 8'h00);
      wr(irq_pkg::OFF_ENABLE, 8'h01);
      src.fire(0);
      for (int g = 0; g < 4; g++) begin
         global_irq_en <= g[0];
         periph_group_irq_en <= g[1];
         tick(3);
         chk_req(g == 3);
      end
      tick(20);
      rd(irq_pkg::OFF_FLAGS, 32'h0000_0001);
      // each flag reaches the core only through its own enable bit
      foreach (bit_tab[i]) begin
         wr(irq_pkg::OFF_FLAGS, 8'h01 << bit_tab[i]);
         wr(irq_pkg::OFF_ENABLE, ~(8'h01 << bit_tab[i]));
         tick(3);
         chk_req(1'b0);
         wr(irq_pkg::OFF_ENABLE, 8'h01 << bit_tab[i]);
         tick(3);
         chk_req(1'b1);
      end
      wr(irq_pkg::OFF_FLAGS, 8'h00);
      tick(3);
      chk_req(1'b0);
      // reset status bits: software marks them, reset events drive them low
      wr(irq_pkg::OFF_POWER, 8'hFF);
      rd(irq_pkg::OFF_POWER, 32'h0000_0003);
      src.fire(5);
      rd(irq_pkg::OFF_POWER, 32'h0000_0001);
      wr(irq_pkg::OFF_POWER, 8'h03);
      src.fire(6);
      rd(irq_pkg::OFF_POWER, 32'h0000_0002);
      wr(irq_pkg::OFF_POWER, 8'h03);
      wr(irq_pkg::OFF_BOR_CTRL, 8'h00);
      tick(2);
      chk({31'h0000_0000, brownout_reset_en}, 32'h0000_0000, "brown-out enable");
      rd(irq_pkg::OFF_POWER, 32'h0000_0002);
      rd(irq_pkg::OFF_BOR_CTRL, 32'h0000_0000);
      wr(irq_pkg::OFF_BOR_CTRL, 8'h01);
      rd(irq_pkg::OFF_POWER, 32'h0000_0003);
      give_verdict();
   end
endmodule // periph_irq_and_reset_status_test
